// file: verilog/prot_pkg.sv
package prot_pkg;
  // ****************************************
  // Function register layout
  // ****************************************
  localparam int FN_RST_DIS   = 0;
  localparam int FN_TBS       = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG      = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG      = 3;
  localparam int FN_IRL_LO    = 4;
  localparam int IR_ROWS      = 4;
  localparam logic [7:0] FN_OTP_MASK = 8'hf3;
  localparam logic [7:0] FN_RESET    = 8'h00;
  // ****************************************
  // Array organisation
  // ****************************************
  localparam int BLK64_COUNT  = 1024;
  localparam int BLK256_COUNT = 256;
  localparam int BLK_AW       = 10;
  localparam logic [3:0] CODE_ALL = 4'hf;
  // Codes 11..14 with 64KB blocks
  localparam logic [10:0] CNT_C11 = 11'd768;
  localparam logic [10:0] CNT_C12 = 11'd896;
  localparam logic [10:0] CNT_C13 = 11'd960;
  localparam logic [10:0] CNT_C14 = 11'd992;
  // ****************************************
  // Operation kinds
  // ****************************************
  typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_CHIP_ERASE, OP_INFO_PROG} op_kind_t;
endpackage

// file: verilog/prot_range.sv
`timescale 1ns/1ps
`default_nettype none
module prot_range (
  // Protection settings
  input  wire logic [3:0]               code,
  input  wire logic                     bottom,
  input  wire logic                     big_blocks,
  // Target block
  input  wire logic [prot_pkg::BLK_AW-1:0] blk,
  // Result
  output logic                          hit
);
  logic [10:0] cnt;
  logic [10:0] total;
  logic [10:0] blk_w;

  always_comb begin
    total = big_blocks ? 11'(prot_pkg::BLK256_COUNT) : 11'(prot_pkg::BLK64_COUNT);
    cnt   = 11'h000;
    if (big_blocks) begin
      if (code == 4'h0) cnt = 11'h000;
      else if (code <= 4'h8) cnt = 11'(11'h001 << (code - 4'h1));
      else cnt = total;
    end else begin
      unique case (code)
        4'h0: cnt = 11'h000;
        4'hb: cnt = prot_pkg::CNT_C11;
        4'hc: cnt = prot_pkg::CNT_C12;
        4'hd: cnt = prot_pkg::CNT_C13;
        4'he: cnt = prot_pkg::CNT_C14;
        4'hf: cnt = total;
        default: cnt = 11'(11'h001 << (code - 4'h1));
      endcase
    end
    blk_w = {1'b0, blk};
    // Top placement ends at last block, bottom grows from block 0
    if (bottom) hit = blk_w < cnt;
    else hit = blk_w >= (total - cnt);
    if (blk_w >= total) hit = 1'b1;
  end
endmodule
`default_nettype wire

// file: verilog/flash_block_protect_function_reg.sv
// What this block does
// - 64KB blocks: decode protect code to count
// - Top/bottom select places the protected range
// - 256KB blocks: codes 9-15 protect all
// - Function register bit layout
// - OTP bits never return to zero
// - Top/bottom resets top, sticky once bottom
// - Program suspend sets flag, resume clears
// - Erase suspend sets flag, resume clears
// - Suspend flags volatile, writes ignored
// - Info row lock refuses row program
// - Reset-disable reset value is a parameter
// - Reset-disable moves reset to hold pin
// - Operations into protected area inhibited
// - Chip erase only when code zero
// - Status write blocked by disable plus pin
`timescale 1ns/1ps
`default_nettype none
module flash_block_protect_function_reg #(
  parameter logic RST_DIS_DEFAULT = 1'b0,
  parameter bit   BIG_BLOCKS      = 1'b0
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // Status register write
  input  wire logic                         status_wr,
  input  wire logic [3:0]                   status_code,
  input  wire logic                         status_swd,
  input  wire logic                         wp_pin_n,
  // Function register write
  input  wire logic                         func_wr,
  input  wire logic [7:0]                   func_wdata,
  // Suspend events from program/erase engines
  input  wire logic                         prog_suspend,
  input  wire logic                         prog_resume,
  input  wire logic                         erase_suspend,
  input  wire logic                         erase_resume,
  // Operation request
  input  wire logic                         op_req,
  input  wire prot_pkg::op_kind_t           op_kind,
  input  wire logic [prot_pkg::BLK_AW-1:0]  op_blk,
  input  wire logic [1:0]                   op_row,
  // Reset pins
  input  wire logic                         ded_reset_pin_n,
  input  wire logic                         hold_reset_pin_n,
  // Results
  output logic                              op_start,
  output logic                              op_reject,
  output logic [7:0]                        func_rdata,
  output logic [3:0]                        protect_code,
  output logic                              status_write_disable,
  output logic                              soft_reset_req
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
    end else begin
      pin_s1_r <= {wp_pin_n, ded_reset_pin_n, hold_reset_pin_n};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic wp_n_s;
  logic ded_n_s;
  logic hold_n_s;
  assign wp_n_s   = pin_s2_r[2];
  assign ded_n_s  = pin_s2_r[1];
  assign hold_n_s = pin_s2_r[0];

  // ****************************************
  // Status bits
  // ****************************************
  logic [3:0] code_r;
  logic       swd_r;
  logic       status_ok;
  assign status_ok = !(swd_r && !wp_n_s);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= 4'h0;
      swd_r  <= 1'b0;
    end else if (status_wr && status_ok) begin
      code_r <= status_code;
      swd_r  <= status_swd;
    end
  end

  // ****************************************
  // Function register
  // ****************************************
  logic [7:0] fn_r;
  logic       init_done_r;
  // Strap-like default loaded after reset release, not under reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_done_r <= 1'b0;
    end else begin
      init_done_r <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fn_r[7:4] <= prot_pkg::FN_RESET[7:4];
      fn_r[1]   <= prot_pkg::FN_RESET[1];
      fn_r[0]   <= prot_pkg::FN_RESET[0];
      fn_r[prot_pkg::FN_PROGRAM_SUSPENDED_FLAG] <= prot_pkg::FN_RESET[prot_pkg::FN_PROGRAM_SUSPENDED_FLAG];
      fn_r[prot_pkg::FN_ERASE_SUSPENDED_FLAG] <= prot_pkg::FN_RESET[prot_pkg::FN_ERASE_SUSPENDED_FLAG];
    end else begin
      if (!init_done_r) fn_r[0] <= RST_DIS_DEFAULT;
      else if (func_wr) fn_r[0] <= fn_r[0] | func_wdata[prot_pkg::FN_RST_DIS];
      if (func_wr) begin
        fn_r[1]   <= fn_r[1] | func_wdata[prot_pkg::FN_TBS];
        fn_r[7:4] <= fn_r[7:4] | func_wdata[7:4];
      end
      // Suspend flags: set wins over resume in same cycle
      if (prog_suspend) fn_r[prot_pkg::FN_PROGRAM_SUSPENDED_FLAG] <= 1'b1;
      else if (prog_resume) fn_r[prot_pkg::FN_PROGRAM_SUSPENDED_FLAG] <= 1'b0;
      if (erase_suspend) fn_r[prot_pkg::FN_ERASE_SUSPENDED_FLAG] <= 1'b1;
      else if (erase_resume) fn_r[prot_pkg::FN_ERASE_SUSPENDED_FLAG] <= 1'b0;
    end
  end

  // ****************************************
  // Protection check
  // ****************************************
  logic hit;
  prot_range u_range (
    .code       (code_r),
    .bottom     (fn_r[prot_pkg::FN_TBS]),
    .big_blocks (BIG_BLOCKS),
    .blk        (op_blk),
    .hit        (hit)
  );
  logic allow;
  always_comb begin
    unique case (op_kind)
      prot_pkg::OP_PROG,
      prot_pkg::OP_ERASE:      allow = !hit;
      prot_pkg::OP_CHIP_ERASE: allow = (code_r == 4'h0);
      prot_pkg::OP_INFO_PROG:  allow = !fn_r[prot_pkg::FN_IRL_LO + 32'(op_row)];
      default:                 allow = 1'b0;
    endcase
  end
  // Decided before the engine starts: a reject never reaches the array
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_start  <= 1'b0;
      op_reject <= 1'b0;
    end else begin
      op_start  <= op_req && allow;
      op_reject <= op_req && !allow;
    end
  end

  // ****************************************
  // Reset routing and read-back
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_req <= 1'b0;
    end else begin
      soft_reset_req <= fn_r[prot_pkg::FN_RST_DIS] ? !hold_n_s : !ded_n_s;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      func_rdata           <= 8'h00;
      protect_code         <= 4'h0;
      status_write_disable <= 1'b0;
    end else begin
      func_rdata           <= fn_r;
      protect_code         <= code_r;
      status_write_disable <= swd_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_otp_sticky;
    @(posedge clk) disable iff (!arst_n)
      init_done_r |=> ($past(fn_r) & prot_pkg::FN_OTP_MASK & ~fn_r) == 8'h00;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky) else $error("otp bit cleared");
  property p_program_suspended_flag_set;
    @(posedge clk) disable iff (!arst_n) prog_suspend |=> fn_r[2];
  endproperty
  a_program_suspended_flag_set: assert property (p_program_suspended_flag_set) else $error("program_suspended_flag not set");
  property p_erase_suspended_flag_clr;
    @(posedge clk) disable iff (!arst_n) (erase_resume && !erase_suspend) |=> !fn_r[3];
  endproperty
  a_erase_suspended_flag_clr: assert property (p_erase_suspended_flag_clr) else $error("erase_suspended_flag not cleared");
  property p_chip_erase;
    @(posedge clk) disable iff (!arst_n)
      (op_req && op_kind == prot_pkg::OP_CHIP_ERASE && code_r != 4'h0) |=> op_reject;
  endproperty
  a_chip_erase: assert property (p_chip_erase) else $error("chip erase not refused");
  property p_wp_block;
    @(posedge clk) disable iff (!arst_n)
      (status_wr && swd_r && !wp_n_s) |=> $stable(code_r);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected status changed");
  property p_start_excl;
    @(posedge clk) disable iff (!arst_n) !(op_start && op_reject);
  endproperty
  a_start_excl: assert property (p_start_excl) else $error("start and reject");
  property p_hit_reject;
    @(posedge clk) disable iff (!arst_n)
      (op_req && op_kind == prot_pkg::OP_ERASE && hit) |=> op_reject && !op_start;
  endproperty
  a_hit_reject: assert property (p_hit_reject) else $error("protected erase started");
  property p_all_code;
    @(posedge clk) disable iff (!arst_n)
      (code_r == prot_pkg::CODE_ALL && op_req && op_kind == prot_pkg::OP_PROG) |=> op_reject;
  endproperty
  a_all_code: assert property (p_all_code) else $error("code 15 not full");
  property p_big_all;
    @(posedge clk) disable iff (!arst_n)
      (BIG_BLOCKS && code_r > 4'h8 && op_req && op_kind == prot_pkg::OP_ERASE) |=> op_reject;
  endproperty
  a_big_all: assert property (p_big_all) else $error("big block code not full");
  property p_rdata;
    @(posedge clk) disable iff (!arst_n) 1'b1 |=> func_rdata == $past(fn_r);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read-back mismatch");
endmodule
`default_nettype wire

// file: tb/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // Clock
  input  wire logic          clk,
  // Register writes
  output logic               status_wr,
  output logic [3:0]         status_code,
  output logic               status_swd,
  output logic               func_wr,
  output logic [7:0]         func_wdata,
  // Engine events
  output logic               prog_suspend,
  output logic               prog_resume,
  output logic               erase_suspend,
  output logic               erase_resume,
  // Operation requests
  output logic               op_req,
  output prot_pkg::op_kind_t op_kind,
  output logic [9:0]         op_blk,
  output logic [1:0]         op_row
);
  initial begin
    {status_wr, status_code, status_swd, func_wr, func_wdata} = '0;
    {prog_suspend, prog_resume, erase_suspend, erase_resume} = 4'h0;
    {op_req, op_blk, op_row} = '0;
    op_kind = prot_pkg::OP_PROG;
  end
  // Qualifiers other than op_kind flip once the strobe drops, so a stale value is never trusted
  task automatic wr_status(input logic [3:0] c, input logic s);
    @(posedge clk);
    {status_wr, status_code, status_swd} <= {1'b1, c, s};
    @(posedge clk);
    {status_wr, status_code, status_swd} <= {1'b0, ~c, ~s};
  endtask
  task automatic wr_func(input logic [7:0] d);
    @(posedge clk);
    {func_wr, func_wdata} <= {1'b1, d};
    @(posedge clk);
    {func_wr, func_wdata} <= {1'b0, ~d};
  endtask
  task automatic evt(input logic [3:0] e);
    @(posedge clk);
    {prog_suspend, prog_resume, erase_suspend, erase_resume} <= e;
    @(posedge clk);
    {prog_suspend, prog_resume, erase_suspend, erase_resume} <= 4'h0;
  endtask
  task automatic op(input prot_pkg::op_kind_t k, input logic [9:0] b, input logic [1:0] r);
    @(posedge clk);
    {op_req, op_blk, op_row} <= {1'b1, b, r};
    op_kind <= k;
    @(posedge clk);
    {op_req, op_blk, op_row} <= {1'b0, ~b, ~r};
  endtask
endmodule
`default_nettype wire

// file: tb/flash_block_protect_function_reg_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module flash_block_protect_function_reg_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, arst_n, wp_pin_n, ded_reset_pin_n, hold_reset_pin_n;
  logic status_wr, status_swd, func_wr, op_req, op_start, op_reject;
  logic prog_suspend, prog_resume, erase_suspend, erase_resume;
  logic status_write_disable, soft_reset_req;
  logic op_start_b, op_reject_b, status_write_disable_b, soft_reset_req_b;
  logic [3:0] protect_code_b;
  logic [7:0] func_rdata_b;
  logic [3:0] status_code, protect_code;
  logic [7:0] func_wdata, func_rdata;
  logic [9:0] op_blk;
  logic [1:0] op_row;
  prot_pkg::op_kind_t op_kind;
  int errors, comparisons, cycles;

  flash_host_model u_host (.clk, .status_wr, .status_code, .status_swd, .func_wr,
    .func_wdata, .prog_suspend, .prog_resume, .erase_suspend, .erase_resume, .op_req,
    .op_kind, .op_blk, .op_row);
  flash_block_protect_function_reg #(.RST_DIS_DEFAULT(1'b0), .BIG_BLOCKS(1'b0)) u_dut (
    .clk, .arst_n, .status_wr, .status_code, .status_swd, .wp_pin_n, .func_wr,
    .func_wdata, .prog_suspend, .prog_resume, .erase_suspend, .erase_resume, .op_req,
    .op_kind, .op_blk, .op_row, .ded_reset_pin_n, .hold_reset_pin_n, .op_start,
    .op_reject, .func_rdata, .protect_code, .status_write_disable, .soft_reset_req);
  // Second build: 256-block table and reset-disable defaulting to 1
  flash_block_protect_function_reg #(.RST_DIS_DEFAULT(1'b1), .BIG_BLOCKS(1'b1)) u_dut_big (
    .clk, .arst_n, .status_wr, .status_code, .status_swd, .wp_pin_n, .func_wr,
    .func_wdata, .prog_suspend, .prog_resume, .erase_suspend, .erase_resume, .op_req,
    .op_kind, .op_blk, .op_row, .ded_reset_pin_n, .hold_reset_pin_n,
    .op_start(op_start_b), .op_reject(op_reject_b), .func_rdata(func_rdata_b),
    .protect_code(protect_code_b), .status_write_disable(status_write_disable_b),
    .soft_reset_req(soft_reset_req_b));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int cnt(input int c);
    return (c == 0) ? 0 : (c <= 10) ? (1 << (c - 1)) : (c == 15) ? 1024 : 1024 - (256 >> (c - 11));
  endfunction
  function automatic logic prot(input int c, input logic bot, input int b);
    return bot ? (b < cnt(c)) : (b >= 1024 - cnt(c));
  endfunction
  function automatic int cnt_b(input int c);
    return (c == 0) ? 0 : (c <= 8) ? (1 << (c - 1)) : 256;
  endfunction
  // Blocks past the 256-block array count as protected
  function automatic logic prot_b(input int c, input logic bot, input int b);
    return (b >= 256) || (bot ? (b < cnt_b(c)) : (b >= 256 - cnt_b(c)));
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_op(input prot_pkg::op_kind_t k, input logic [9:0] b,
                          input logic [1:0] r, input logic rej, input logic rej_b);
    u_host.op(k, b, r);
    #1;
    `CHK({op_start, op_reject, op_start_b, op_reject_b}, {~rej, rej, ~rej_b, rej_b})
  endtask
  // Second build starts with reset-disable set, and it stays set
  task automatic chk_func(input logic [7:0] e);
    wait_n(2);
    `CHK({func_rdata, func_rdata_b}, {e, e | 8'h01})
  endtask
  // Edge blocks on both sides of the range boundary, plus whole-chip erase
  task automatic sweep(input logic bot);
    logic [9:0] b_in;
    logic [9:0] b_out;
    logic [9:0] b_bin;
    logic [9:0] b_bout;
    for (int c = 0; c < 16; c++) begin
      b_in   = bot ? 10'(cnt(c) - 1) : 10'(1024 - cnt(c));
      b_out  = bot ? b_in + 10'h1 : b_in - 10'h1;
      b_bin  = bot ? 10'(cnt_b(c) - 1) : 10'(256 - cnt_b(c));
      b_bout = bot ? 10'(cnt_b(c)) : 10'(255 - cnt_b(c));
      u_host.wr_status(c[3:0], 1'b0);
      wait_n(2);
      `CHK({protect_code, protect_code_b}, {c[3:0], c[3:0]})
      check_op(prot_pkg::OP_PROG, b_in, 2'd0, prot(c, bot, int'(b_in)),
               prot_b(c, bot, int'(b_in)));
      check_op(prot_pkg::OP_ERASE, b_out, 2'd0, prot(c, bot, int'(b_out)),
               prot_b(c, bot, int'(b_out)));
      check_op(prot_pkg::OP_ERASE, b_bin, 2'd0, prot(c, bot, int'(b_bin)),
               prot_b(c, bot, int'(b_bin)));
      check_op(prot_pkg::OP_PROG, b_bout, 2'd0, prot(c, bot, int'(b_bout)),
               prot_b(c, bot, int'(b_bout)));
      check_op(prot_pkg::OP_CHIP_ERASE, 10'h0, 2'd0, c != 0, c != 0);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    {arst_n, wp_pin_n, ded_reset_pin_n, hold_reset_pin_n} = 4'b0111;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    wait_n(2);
    `CHK({func_rdata, func_rdata_b}, 16'h0001)
    sweep(1'b0);
    u_host.wr_func(8'h0e);
    chk_func(8'h02);
    u_host.wr_func(8'h00);
    chk_func(8'h02);
    sweep(1'b1);
    u_host.evt(4'b1000);
    chk_func(8'h06);
    u_host.evt(4'b0010);
    chk_func(8'h0e);
    u_host.evt(4'b0100);
    chk_func(8'h0a);
    u_host.evt(4'b0011);
    chk_func(8'h0a);
    u_host.evt(4'b0001);
    chk_func(8'h02);
    u_host.wr_func(8'h50);
    chk_func(8'h52);
    check_op(prot_pkg::OP_INFO_PROG, 10'h0, 2'd0, 1'b1, 1'b1);
    check_op(prot_pkg::OP_INFO_PROG, 10'h0, 2'd1, 1'b0, 1'b0);
    check_op(prot_pkg::OP_INFO_PROG, 10'h0, 2'd2, 1'b1, 1'b1);
    check_op(prot_pkg::OP_INFO_PROG, 10'h0, 2'd3, 1'b0, 1'b0);
    u_host.wr_status(4'h3, 1'b1);
    @(posedge clk) wp_pin_n <= 1'b0;
    wait_n(4);
    u_host.wr_status(4'h7, 1'b0);
    wait_n(2);
    `CHK({status_write_disable, protect_code, status_write_disable_b, protect_code_b}, 10'h273)
    @(posedge clk) wp_pin_n <= 1'b1;
    wait_n(4);
    u_host.wr_status(4'h0, 1'b0);
    wait_n(2);
    `CHK({status_write_disable, protect_code, status_write_disable_b, protect_code_b}, 10'h000)
    @(posedge clk) hold_reset_pin_n <= 1'b0;
    wait_n(5);
    `CHK({soft_reset_req, soft_reset_req_b}, 2'b01)
    @(posedge clk) ded_reset_pin_n <= 1'b0;
    wait_n(5);
    `CHK({soft_reset_req, soft_reset_req_b}, 2'b11)
    @(posedge clk) {ded_reset_pin_n, hold_reset_pin_n} <= 2'b11;
    u_host.wr_func(8'h01);
    chk_func(8'h53);
    @(posedge clk) ded_reset_pin_n <= 1'b0;
    wait_n(5);
    `CHK({soft_reset_req, soft_reset_req_b}, 2'b00)
    @(posedge clk) hold_reset_pin_n <= 1'b0;
    wait_n(5);
    `CHK({soft_reset_req, soft_reset_req_b}, 2'b11)
    end_of_test();
  end
endmodule
`default_nettype wire
